/* verilog/gpmc_top.sv */
// Top: eight pins, modem nibble select, pin interrupts and software reset
//
// What this block does
// RQ1: Reading the level register returns the pin state for inputs and the written level for outputs.
// RQ2: Writing the level register drives each output pin of a general-purpose nibble low for 0, high for 1.
// RQ3: An enable register gives each pin its own interrupt, 1 enables.
// RQ4: Enable bits do nothing for pins of a nibble given to modem use.
// RQ5: Writing 1 to control bit 3 resets the device, all but the status and status mask registers.
// RQ6: The software reset bit is never stored, so it always reads back 0.
// RQ7: Control bit 2 gives the lower nibble to the second channel's modem lines.
// RQ8: Control bit 1 gives the upper nibble to the first channel's modem lines.
// RQ9: Without latching, a pending pin change goes if the pin returns; the sticky status bit stays set.
// RQ10: With latching, it stays and the level bit keeps the causing value.
// RQ11: The group is shared; its software reset resets every channel.
// RQ12: After reset output levels are all ones, enable and control read zero.
// RQ13: A direction register makes a pin of a general-purpose nibble an output on 1; default all inputs.
// RQ14: An enabled input pin change sets the pin status bit, raising the interrupt if unmasked; a status register read clears it.
`timescale 1ns/1ns
module gpmc_top
  import gpmc_pkg::*;
(
  input  wire logic                     CLK,
  input  wire logic                     RESET,
  input  wire logic [3:0]               ADDR,
  input  wire logic [7:0]               WDATA,
  input  wire logic                     WR,
  input  wire logic                     RD,
  output logic      [7:0]               RDATA,
  input  wire logic [7:0]               PIN_IN,
  output logic      [7:0]               PIN_OUT,
  output logic      [7:0]               PIN_OE,
  input  wire logic                     TERMINAL_READY_FIRST_N,
  input  wire logic                     TERMINAL_READY_SECOND_N,
  output gpmc_pkg::gpmc_modem_in_t      MODEM_FIRST,
  output gpmc_pkg::gpmc_modem_in_t      MODEM_SECOND,
  output logic                          DEVICE_RESET,
  output logic                          IRQ
);
  import gpmc_pkg::*;

  gpmc_bus_t          bus;
  logic [7:0]         dir_r;
  logic [7:0]         out_r;
  logic [7:0]         irqen_r;
  logic [7:0]         func_r;
  logic [IRQ_W-1:0]   istat_r;
  logic [IRQ_W-1:0]   imask_r;
  logic [7:0]         pin_s;
  logic [7:0]         armed;
  logic [7:0]         pend;
  logic [7:0]         view;
  logic [7:0]         gpio_sel;
  logic               level_rd;
  logic               istat_rd;
  logic               swrst_go;
  logic [2:0]         swrst_cnt_r;
  logic               srst;
  logic               pin_evt;
  logic               pin_evt_d_r;
  logic [7:0]         oe_nxt;
  logic [7:0]         out_nxt;

  assign bus = '{wr: WR, rd: RD, addr: ADDR, wdata: WDATA};
  assign level_rd = bus.rd && gpmc_hit(bus.addr, ADDR_LEVEL);
  assign istat_rd = bus.rd && gpmc_hit(bus.addr, ADDR_ISTAT);
  assign swrst_go = bus.wr && gpmc_hit(bus.addr, ADDR_FUNC)
                    && bus.wdata[FB_SWRST];             // see RQ5
  // Internal reset: pin reset or the software reset pulse
  assign srst = RESET || (swrst_cnt_r != 3'd0);         // see RQ11

  // Nibble ownership: 1 where a pin is general purpose
  assign gpio_sel = {{4{~func_r[FB_MDM_HI]}},
                     {4{~func_r[FB_MDM_LO]}}};           // see RQ7 RQ8
  // Modem nibbles mask the enables; outputs never interrupt
  assign armed = irqen_r & gpio_sel & ~dir_r;           // see RQ3 RQ4 RQ14

  gpmc_sync #(.W(8)) i_gpmc_sync (
    .CLK (CLK),
    .D   (PIN_IN),
    .Q   (pin_s)
  );

  gpmc_pinchg #(.W(8)) i_gpmc_pinchg (
    .CLK   (CLK),
    .RST   (srst),
    .PIN   (pin_s),
    .ARMED (armed),
    .LATCH (func_r[FB_LATCH]),
    .ACK   (level_rd),
    .PEND  (pend),
    .VIEW  (view)
  );

  // Software reset stretched over a few cycles, then the bit reads 0
  always_ff @(posedge CLK) begin
    if (RESET) begin
      swrst_cnt_r <= 3'd0;
    end else if (swrst_go) begin
      swrst_cnt_r <= 3'(SWRST_CYC);                     // see RQ5
    end else if (swrst_cnt_r != 3'd0) begin
      swrst_cnt_r <= swrst_cnt_r - 3'd1;                // see RQ6
    end
  end

  // Direction register
  always_ff @(posedge CLK) begin
    if (srst) begin
      dir_r <= RST_DIR;                                 // see RQ13
    end else if (bus.wr && gpmc_hit(bus.addr, ADDR_DIR)) begin
      dir_r <= bus.wdata;
    end
  end

  // Output level register, resets high
  always_ff @(posedge CLK) begin
    if (srst) begin
      out_r <= RST_LEVEL;                               // see RQ12
    end else if (bus.wr && gpmc_hit(bus.addr, ADDR_LEVEL)) begin
      out_r <= bus.wdata;                               // see RQ2
    end
  end

  // Interrupt enable
  always_ff @(posedge CLK) begin
    if (srst) begin
      irqen_r <= RST_IRQEN;                             // see RQ12
    end else if (bus.wr && gpmc_hit(bus.addr, ADDR_IRQEN)) begin
      irqen_r <= bus.wdata;                             // see RQ3
    end
  end

  // Function control; bit 3 never stores, so it always reads back 0
  always_ff @(posedge CLK) begin
    if (srst) begin
      func_r <= RST_FUNC;                               // see RQ12
    end else if (bus.wr && gpmc_hit(bus.addr, ADDR_FUNC)) begin
      func_r <= bus.wdata & FUNC_WMASK & ~(8'h01 << FB_SWRST); // see RQ6
    end
  end

  // Status mask; only the pin reset clears it, so it survives a soft reset
  always_ff @(posedge CLK) begin
    if (RESET) begin
      imask_r <= RST_IMASK[IRQ_W-1:0];
    end else if (bus.wr && gpmc_hit(bus.addr, ADDR_IMASK)) begin
      imask_r <= bus.wdata[IRQ_W-1:0];
    end
  end

  // Rising edge of any pending pin change
  assign pin_evt = |pend;
  always_ff @(posedge CLK) begin
    if (RESET) begin
      pin_evt_d_r <= 1'b0;
    end else begin
      pin_evt_d_r <= pin_evt;
    end
  end

  // Sticky status; a set in the read cycle wins over the clear
  always_ff @(posedge CLK) begin
    if (RESET) begin
      istat_r <= '0;
    end else begin
      if (istat_rd) begin
        istat_r <= '0;
      end
      if (pin_evt && !pin_evt_d_r) begin
        istat_r[IB_PIN] <= 1'b1;                        // see RQ14
      end
      if (swrst_go) begin
        istat_r[IB_SWRST] <= 1'b1;
      end
    end
  end

  // Interrupt: any unmasked sticky status bit, registered
  always_ff @(posedge CLK) begin
    if (RESET) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(istat_r & imask_r);                      // see RQ14
    end
  end

  // Pin drivers; modem nibbles carry the terminal-ready lines
  always_comb begin
    oe_nxt  = dir_r & gpio_sel;                         // see RQ13
    out_nxt = out_r;
    if (func_r[FB_MDM_HI]) begin
      oe_nxt[5]  = 1'b1;                                // see RQ8
      out_nxt[5] = TERMINAL_READY_FIRST_N;
    end
    if (func_r[FB_MDM_LO]) begin
      oe_nxt[1]  = 1'b1;                                // see RQ7
      out_nxt[1] = TERMINAL_READY_SECOND_N;
    end
  end

  always_ff @(posedge CLK) begin
    if (srst) begin
      PIN_OE  <= RST_DIR;
      PIN_OUT <= RST_LEVEL;
    end else begin
      PIN_OE  <= oe_nxt;
      PIN_OUT <= out_nxt;                               // see RQ2
    end
  end

  // Modem inputs to the channels: ring 7/3, carrier 6/2, set-ready 4/0
  always_ff @(posedge CLK) begin
    if (srst) begin
      MODEM_FIRST  <= '1;
      MODEM_SECOND <= '1;
    end else begin
      MODEM_FIRST  <= func_r[FB_MDM_HI] ?
                      {pin_s[7], pin_s[6], pin_s[4]} : 3'b111;
      MODEM_SECOND <= func_r[FB_MDM_LO] ?
                      {pin_s[3], pin_s[2], pin_s[0]} : 3'b111;
    end
  end

  // Device-wide reset out to every channel
  always_ff @(posedge CLK) begin
    if (RESET) begin
      DEVICE_RESET <= 1'b1;
    end else begin
      DEVICE_RESET <= swrst_go || (swrst_cnt_r > 3'd1); // see RQ11
    end
  end

  // Read data, valid the cycle after the strobe
  always_ff @(posedge CLK) begin
    if (RESET) begin
      RDATA <= 8'h00;
    end else if (bus.rd) begin
      case (bus.addr)
        ADDR_DIR:   RDATA <= dir_r;
        ADDR_LEVEL: RDATA <= (view & ~dir_r) | (out_r & dir_r); // see RQ1
        ADDR_IRQEN: RDATA <= irqen_r;
        ADDR_FUNC:  RDATA <= func_r;
        ADDR_ISTAT: RDATA <= {{(8-IRQ_W){1'b0}}, istat_r};
        ADDR_IMASK: RDATA <= {{(8-IRQ_W){1'b0}}, imask_r};
        default:    RDATA <= 8'h00;
      endcase
    end else begin
      RDATA <= 8'h00;
    end
  end

  // Checks
  property p_swrst_bit_clears;
    @(posedge CLK) disable iff (RESET)
      swrst_go |=> !func_r[FB_SWRST];
  endproperty
  a_swrst_bit_clears: assert property (p_swrst_bit_clears) // see RQ6
    else $error("software reset bit stayed set");

  property p_swrst_resets;
    @(posedge CLK) disable iff (RESET)
      swrst_go |=> ##1 (irqen_r == RST_IRQEN && dir_r == RST_DIR);
  endproperty
  a_swrst_resets: assert property (p_swrst_resets) // see RQ5
    else $error("software reset did not reset registers");

  property p_devrst_out;
    @(posedge CLK) disable iff (RESET)
      swrst_go |=> DEVICE_RESET [*3];
  endproperty
  a_devrst_out: assert property (p_devrst_out) // see RQ11
    else $error("device reset pulse too short");

  // Enables trail the direction register by one cycle
  property p_oe_follows_dir;
    @(posedge CLK) disable iff (srst)
      (func_r[2:1] == 2'b00) |=> PIN_OE == $past(dir_r);
  endproperty
  a_oe_follows_dir: assert property (p_oe_follows_dir) // see RQ13
    else $error("pin enable differs from direction");

  property p_out_follows_level;
    @(posedge CLK) disable iff (srst)
      bus.wr && gpmc_hit(bus.addr, ADDR_LEVEL) && func_r[2:1] == 2'b00
      |=> ##1 PIN_OUT == $past(bus.wdata, 2);
  endproperty
  a_out_follows_level: assert property (p_out_follows_level) // see RQ2
    else $error("output pins do not show written level");

  property p_modem_masks;
    @(posedge CLK) disable iff (srst)
      func_r[FB_MDM_HI] |-> armed[7:4] == 4'h0;
  endproperty
  a_modem_masks: assert property (p_modem_masks) // see RQ4
    else $error("modem nibble still armed");

  property p_read_acks;
    @(posedge CLK) disable iff (srst)
      level_rd && !func_r[FB_LATCH] ##1 $stable(pin_s) |-> pend == 8'h00;
  endproperty
  a_read_acks: assert property (p_read_acks) // see RQ14
    else $error("level read left a pending change");

  property p_irq_level;
    @(posedge CLK) disable iff (RESET)
      (|(istat_r & imask_r)) |=> IRQ;
  endproperty
  a_irq_level: assert property (p_irq_level) // see RQ14
    else $error("interrupt output not raised");

  c_swrst: cover property (@(posedge CLK) swrst_go);
  c_pin_irq: cover property (@(posedge CLK) istat_r[IB_PIN] && IRQ);
  c_latched: cover property (@(posedge CLK)
    func_r[FB_LATCH] && pend != 8'h00);
endmodule

/* verilog/gpmc_pkg.sv */
// Package: register map, field positions and carrier types for the pin block
package gpmc_pkg;
  localparam int unsigned NPINS = 8;
  localparam logic [3:0] ADDR_DIR    = 4'hA;
  localparam logic [3:0] ADDR_LEVEL  = 4'hB;
  localparam logic [3:0] ADDR_IRQEN  = 4'hC;
  localparam logic [3:0] ADDR_FUNC   = 4'hE;
  localparam logic [3:0] ADDR_ISTAT  = 4'h4;
  localparam logic [3:0] ADDR_IMASK  = 4'h5;
  localparam logic [7:0] RST_DIR     = 8'h00;
  localparam logic [7:0] RST_LEVEL   = 8'hFF;
  localparam logic [7:0] RST_IRQEN   = 8'h00;
  localparam logic [7:0] RST_FUNC    = 8'h00;
  localparam logic [7:0] RST_IMASK   = 8'h00;
  localparam int unsigned FB_LATCH   = 0;
  localparam int unsigned FB_MDM_HI  = 1;
  localparam int unsigned FB_MDM_LO  = 2;
  localparam int unsigned FB_SWRST   = 3;
  localparam logic [7:0] FUNC_WMASK  = 8'h0F;
  // Interrupt status bits
  localparam int unsigned IB_PIN     = 0;
  localparam int unsigned IB_SWRST   = 1;
  localparam int unsigned IRQ_W      = 2;
  // Software reset pulse length in cycles
  localparam int unsigned SWRST_CYC  = 4;

  // Modem lines of one channel, active low on the pins
  typedef struct packed {
    logic ring_n;
    logic carrier_n;
    logic set_ready_n;
  } gpmc_modem_in_t;

  // Register bus request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } gpmc_bus_t;

  // Decode of a register address
  function automatic logic gpmc_hit(input logic [3:0] a,
                                    input logic [3:0] b);
    return a == b;
  endfunction
endpackage

/* verilog/gpmc_sync.sv */
// Two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ns
module gpmc_sync #(
  parameter int unsigned W = 8
) (
  input  wire logic         CLK,
  input  wire logic [W-1:0] D,
  output logic      [W-1:0] Q
);
  logic [W-1:0] meta_r;

  // First stage feeds only the second; no reset so no pin reaches a reset mux
  always_ff @(posedge CLK) begin
    meta_r <= D;
    Q      <= meta_r;
  end
endmodule

/* verilog/gpmc_pinchg.sv */
// Per-pin change detector with optional latching of the causing level
`timescale 1ns/1ns
module gpmc_pinchg #(
  parameter int unsigned W = 8
) (
  input  wire logic         CLK,
  input  wire logic         RST,
  input  wire logic [W-1:0] PIN,
  input  wire logic [W-1:0] ARMED,
  input  wire logic         LATCH,
  input  wire logic         ACK,
  output logic      [W-1:0] PEND,
  output logic      [W-1:0] VIEW
);
  logic [W-1:0] ref_r;
  logic [W-1:0] held_r;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_pin
      // Reference level is the one last seen by software
      always_ff @(posedge CLK) begin
        if (RST) begin
          ref_r[i]  <= 1'b1;
          PEND[i]   <= 1'b0;
          held_r[i] <= 1'b1;
        end else if (ACK) begin
          ref_r[i]  <= VIEW[i];
          PEND[i]   <= 1'b0;
          held_r[i] <= PIN[i];
        end else if (!ARMED[i]) begin
          ref_r[i]  <= PIN[i];
          PEND[i]   <= 1'b0;
          held_r[i] <= PIN[i];
        end else if (LATCH) begin
          // Sticky: keep the level that raised it (see RQ10)
          if (!PEND[i] && PIN[i] != ref_r[i]) begin
            PEND[i]   <= 1'b1;
            held_r[i] <= PIN[i];
          end else if (!PEND[i]) begin
            held_r[i] <= PIN[i];
          end
        end else begin
          // Withdrawn if the pin returns before the read (see RQ9)
          PEND[i]   <= PIN[i] != ref_r[i];
          held_r[i] <= PIN[i];
        end
      end
      assign VIEW[i] = (LATCH && PEND[i]) ? held_r[i] : PIN[i];
    end
  endgenerate
endmodule

/* bench/gpmc_board.sv */
// Board model: drives the eight pins, follows the block where it drives
`timescale 1ns/1ns
module gpmc_board (
  input  wire logic       CLK,
  input  wire logic       SLOW,
  input  wire logic [7:0] DRIVE,
  input  wire logic [7:0] PIN_OUT,
  input  wire logic [7:0] PIN_OE,
  output logic      [7:0] PIN_IN
);
  logic [7:0] drive_r;

  // Slow mode lags the board levels by a cycle
  always_ff @(posedge CLK) begin
    drive_r <= DRIVE;
  end

  // Board lets go of a pin the block drives, so the wire shows the block
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      PIN_IN[i] = PIN_OE[i] ? PIN_OUT[i] : (SLOW ? drive_r[i] : DRIVE[i]);
    end
  end
endmodule

/* bench/gpmc_top_test.sv */
// Self-checking bench for the pin block with its board model
`timescale 1ns/1ns
module gpmc_top_test;
  import gpmc_pkg::*;
  logic           clk;
  logic           reset;
  logic [3:0]     addr;
  logic [7:0]     wdata;
  logic           wr;
  logic           rd;
  logic [7:0]     rdata;
  logic [7:0]     pin_in;
  logic [7:0]     pin_out;
  logic [7:0]     pin_oe;
  logic           tr_first_n;
  logic           tr_second_n;
  gpmc_modem_in_t modem_first;
  gpmc_modem_in_t modem_second;
  logic           device_reset;
  logic           irq;
  logic [7:0]     drive;
  logic           slow;
  logic [7:0]     v;
  logic [7:0]     d;
  logic [7:0]     l;
  integer         seed;
  int             error_cnt;
  int             comparisons;
  int             cyc;
  int             cnt;

  gpmc_top i_gpmc_top (.CLK(clk), .RESET(reset), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .PIN_IN(pin_in), .PIN_OUT(pin_out),
    .PIN_OE(pin_oe), .TERMINAL_READY_FIRST_N(tr_first_n),
    .TERMINAL_READY_SECOND_N(tr_second_n), .MODEM_FIRST(modem_first),
    .MODEM_SECOND(modem_second), .DEVICE_RESET(device_reset), .IRQ(irq));

  gpmc_board i_gpmc_board (.CLK(clk), .SLOW(slow), .DRIVE(drive),
    .PIN_OUT(pin_out), .PIN_OE(pin_oe), .PIN_IN(pin_in));

  // Clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Expected level read: written value on outputs, board level on inputs
  function automatic logic [7:0] exp_level(input logic [7:0] dr,
                                           input logic [7:0] lv,
                                           input logic [7:0] bd);
    return (dr & lv) | (~dr & bd);
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One-cycle write strobe
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] dat);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= dat;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] dat);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 dat = rdata;
  endtask

  task automatic report_and_stop();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      report_and_stop();
    end
  end

  initial begin
    reset = 1'b1; addr = 4'h0; wdata = 8'h00; wr = 1'b0; rd = 1'b0;
    drive = 8'hFF; slow = 1'b0; tr_first_n = 1'b1; tr_second_n = 1'b1;
    seed = 16652; error_cnt = 0; comparisons = 0; cyc = 0;
    tick(2);
    reset <= 1'b0;
    // Reset values, plus an unmapped place
    rd_reg(ADDR_LEVEL, v);
    chk(v, 8'hFF);
    rd_reg(ADDR_IRQEN, v);
    chk(v, 8'h00);
    rd_reg(ADDR_FUNC, v);
    chk(v, 8'h00);
    rd_reg(ADDR_DIR, v);
    chk(v, 8'h00);
    wr_reg(4'hD, 8'h5A);
    rd_reg(4'hD, v);
    chk(v, 8'h00);
    // Random directions, levels and board values
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      d = 8'($random(seed));
      l = 8'($random(seed));
      drive <= 8'($random(seed));
      slow <= i[0];
      wr_reg(ADDR_DIR, d);
      wr_reg(ADDR_LEVEL, l);
      tick(4);
      chk(pin_oe, d);
      chk(pin_out & d, l & d);
      rd_reg(ADDR_LEVEL, v);
      chk(v, exp_level(d, l, drive));
    end
    // Only enabled pins interrupt
    @(posedge clk);
    drive <= 8'hFF;
    slow <= 1'b0;
    wr_reg(ADDR_DIR, 8'h00);
    wr_reg(ADDR_IRQEN, 8'h01);
    tick(6);
    rd_reg(ADDR_LEVEL, v);
    rd_reg(ADDR_ISTAT, v);
    @(posedge clk);
    drive <= 8'hFD;
    tick(8);
    rd_reg(ADDR_ISTAT, v);
    chk(v & 8'h01, 8'h00);
    @(posedge clk);
    drive <= 8'hFF;
    tick(6);
    rd_reg(ADDR_LEVEL, v);
    // A pulse on pin 0, latching off then on; mask on in the first pass
    for (int m = 0; m < 2; m++) begin
      wr_reg(ADDR_FUNC, m[7:0]);
      wr_reg(ADDR_IMASK, {7'h00, ~m[0]});
      rd_reg(ADDR_ISTAT, v);
      @(posedge clk);
      drive <= 8'hFE;
      tick(8);
      chk({7'h00, irq}, {7'h00, ~m[0]});
      @(posedge clk);
      drive <= 8'hFF;
      tick(6);
      rd_reg(ADDR_ISTAT, v);
      chk(v & 8'h01, 8'h01);
      rd_reg(ADDR_ISTAT, v);
      chk(v & {7'h00, ~m[0]}, 8'h00);
      rd_reg(ADDR_LEVEL, v);
      chk(v, m[0] ? 8'hFE : 8'hFF);
      rd_reg(ADDR_LEVEL, v);
      chk(v, 8'hFF);
      tick(2);
      chk({7'h00, irq}, 8'h00);
    end
    // Each nibble in modem use; its enable bits must not interrupt
    for (int n = 0; n < 2; n++) begin
      @(posedge clk);
      drive <= 8'hFF;
      tr_first_n <= n[0];
      tr_second_n <= ~n[0];
      wr_reg(ADDR_FUNC, n[0] ? 8'h04 : 8'h02);
      wr_reg(ADDR_IRQEN, 8'hFF);
      tick(8);
      rd_reg(ADDR_LEVEL, v);
      rd_reg(ADDR_ISTAT, v);
      @(posedge clk);
      drive <= n[0] ? 8'hF6 : 8'h6F;
      tick(8);
      rd_reg(ADDR_ISTAT, v);
      chk(v & 8'h01, 8'h00);
      chk({5'h00, modem_first}, n[0] ? 8'h07 : 8'h02);
      chk({5'h00, modem_second}, n[0] ? 8'h02 : 8'h07);
      chk(pin_oe, n[0] ? 8'h02 : 8'h20);
      chk(pin_out & pin_oe, 8'h00);
    end
    // Reserved control bits, then a software reset with setup in place
    wr_reg(ADDR_FUNC, 8'hF1);
    rd_reg(ADDR_FUNC, v);
    chk(v, 8'h01);
    wr_reg(ADDR_DIR, 8'hFF);
    wr_reg(ADDR_IRQEN, 8'h5A);
    wr_reg(ADDR_FUNC, 8'h09);
    cnt = 0;
    // First sample is the cycle launched by the write itself
    for (int k = 0; k < 10; k++) begin
      #1 cnt = cnt + int'(device_reset);
      @(posedge clk);
    end
    chk(cnt[7:0], SWRST_CYC[7:0]);
    rd_reg(ADDR_FUNC, v);
    chk(v, 8'h00);
    rd_reg(ADDR_DIR, v);
    chk(v, 8'h00);
    rd_reg(ADDR_IRQEN, v);
    chk(v, 8'h00);
    rd_reg(ADDR_LEVEL, v);
    chk(v, exp_level(8'h00, 8'hFF, drive));
    chk(pin_out, 8'hFF);
    rd_reg(ADDR_ISTAT, v);
    chk(v & 8'h02, 8'h02);
    chk(pin_oe, 8'h00);
    report_and_stop();
  end
endmodule
